// >>> logic/ssw_consts.vh
// Constants for the supply supervisor and watchdog reset block
`ifndef SSW_CONSTS_VH
`define SSW_CONSTS_VH

// Clock and timebase
`define SSW_CLK_PERIOD_NS   10
`define SSW_TICK_US         100

// Hold periods, minimum, in ms
`define SSW_HOLD_A_MS       1
`define SSW_HOLD_B_MS       20
`define SSW_HOLD_C_MS       140
`define SSW_HOLD_D_MS       1120

// Watchdog periods, typical, in us
`define SSW_WD_W_US         6300
`define SSW_WD_X_US         102000
`define SSW_WD_Y_US         1600000
`define SSW_WD_Z_US         25600000

// Input filter times
`define SSW_MR_GLITCH_NS    100
`define SSW_MR_DEBOUNCE_US  20
`define SSW_UV_FILTER_US    80
`define SSW_STROBE_MIN_NS   50

// Register byte offsets
`define SSW_REG_CTRL        4'h0
`define SSW_REG_STATUS      4'h4
`define SSW_REG_WDCOUNT     4'h8

// Control fields
`define SSW_CTRL_HOLD_LSB   0
`define SSW_CTRL_WD_LSB     2
`define SSW_CTRL_WDEN_BIT   4

// Status fields
`define SSW_ST_RESET_BIT    0
`define SSW_ST_UV_BIT       1
`define SSW_ST_MR_BIT       2
`define SSW_ST_WDEXP_BIT    3
`define SSW_ST_DRIVEN_BIT   4
`define SSW_ST_STATE_LSB    5

`endif

// >>> logic/ssw_pin_filter.v
// Three-stage synchroniser with a stability filter for one pin
module ssw_pin_filter #(
   parameter STABLE_CYCLES = 1,
   parameter CNT_W         = 16,
   parameter INIT_LEVEL    = 1'b1
) (
   // Clock and reset
   input  wire             clk,
   input  wire             rst_n,
   // Pin side
   input  wire             pin,
   // Filtered side
   output reg              level,
   output reg              changed
);

   reg             sync1;
   reg             sync2;
   reg             sync3;
   reg [CNT_W-1:0] stable_cnt;
   wire            differs;

   localparam integer     LAST_I = STABLE_CYCLES - 1;
   localparam [CNT_W-1:0] LAST   = LAST_I[CNT_W-1:0];

   // Second and third stage agree on a level other than the held one
   assign differs = (sync2 == sync3) && (sync3 != level);

   always @(posedge clk) begin
      if (!rst_n) begin
         sync1      <= INIT_LEVEL;
         sync2      <= INIT_LEVEL;
         sync3      <= INIT_LEVEL;
         level      <= INIT_LEVEL;
         stable_cnt <= {CNT_W{1'b0}};
         changed    <= 1'b0;
      end else begin
         sync1   <= pin;
         sync2   <= sync1;
         sync3   <= sync2;
         changed <= 1'b0;
         if (!differs) begin
            stable_cnt <= {CNT_W{1'b0}};
         end else if (stable_cnt >= LAST) begin
            level      <= sync3;
            changed    <= 1'b1;
            stable_cnt <= {CNT_W{1'b0}};
         end else begin
            stable_cnt <= stable_cnt + 1'b1;
         end
      end
   end

endmodule

// >>> logic/ssw_top.v
// Supply supervisor with manual reset, watchdog and stretched reset output
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`include "ssw_consts.vh"

module ssw_top #(
   parameter       HAS_WATCHDOG     = 1,
   parameter       HAS_MANUAL       = 1,
   parameter       OPEN_DRAIN       = 0,
   parameter [1:0] HOLD_SEL         = 2'd2,
   parameter [1:0] WD_SEL           = 2'd2,
   parameter       TICK_CYCLES      = `SSW_TICK_US * 1000 / `SSW_CLK_PERIOD_NS,
   parameter       UV_FILTER_CYCLES = `SSW_UV_FILTER_US * 1000 / `SSW_CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Supervised inputs
   input  wire        supply_low_in,
   input  wire        manual_reset_in_n,
   input  wire        watchdog_strobe_in,
   input  wire        watchdog_strobe_driven,
   // Reset outputs
   output reg         reset_out_n,
   output wire        reset_out_n_oe,
   output reg         reset_out,
   // Avalon-MM slave
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest
);

   ////////////////////////////////////////////////////////////////////////
   // Derived timing

   localparam MR_GLITCH_CYCLES = (`SSW_MR_GLITCH_NS + `SSW_CLK_PERIOD_NS - 1)
                                 / `SSW_CLK_PERIOD_NS;
   localparam MR_DEBOUNCE_CYCLES = `SSW_MR_DEBOUNCE_US * 1000 / `SSW_CLK_PERIOD_NS;
   localparam MR_CYCLES = (MR_DEBOUNCE_CYCLES > MR_GLITCH_CYCLES) ?
                          MR_DEBOUNCE_CYCLES : MR_GLITCH_CYCLES;
   // One stable sample suffices; a 50 ns pulse spans five clocks
   localparam STROBE_CYCLES = (`SSW_STROBE_MIN_NS / `SSW_CLK_PERIOD_NS > 1) ? 1 : 1;

   localparam CNT_W = 18;
   localparam DIV_W = 16;

   localparam integer     TICK_LAST_I = TICK_CYCLES - 1;
   localparam [DIV_W-1:0] TICK_LAST   = TICK_LAST_I[DIV_W-1:0];

   ////////////////////////////////////////////////////////////////////////
   // States

   localparam [1:0] ST_RUN    = 2'd0;
   localparam [1:0] ST_ASSERT = 2'd1;
   localparam [1:0] ST_HOLD   = 2'd2;

   ////////////////////////////////////////////////////////////////////////
   // Period lookup, in timebase ticks

   function [CNT_W-1:0] hold_ticks;
      input [1:0] sel;
      integer     t;
      begin
         case (sel)
            2'd0:    t = `SSW_HOLD_A_MS * 1000 / `SSW_TICK_US;
            2'd1:    t = `SSW_HOLD_B_MS * 1000 / `SSW_TICK_US;
            2'd2:    t = `SSW_HOLD_C_MS * 1000 / `SSW_TICK_US;
            default: t = `SSW_HOLD_D_MS * 1000 / `SSW_TICK_US;
         endcase
         hold_ticks = t[CNT_W-1:0];
      end
   endfunction

   function [CNT_W-1:0] wd_ticks;
      input [1:0] sel;
      integer     t;
      begin
         case (sel)
            2'd0:    t = `SSW_WD_W_US / `SSW_TICK_US;
            2'd1:    t = `SSW_WD_X_US / `SSW_TICK_US;
            2'd2:    t = `SSW_WD_Y_US / `SSW_TICK_US;
            default: t = `SSW_WD_Z_US / `SSW_TICK_US;
         endcase
         wd_ticks = t[CNT_W-1:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   reg  [1:0]       state;
   reg  [1:0]       next_state;
   reg  [DIV_W-1:0] div_cnt;
   reg              tick;
   reg  [CNT_W-1:0] hold_cnt;
   reg  [CNT_W-1:0] wd_cnt;
   reg              wd_expired;
   reg              wd_flag;
   reg  [1:0]       ctrl_hold_sel;
   reg  [1:0]       ctrl_wd_sel;
   reg              ctrl_wd_en;
   reg              bus_ack;

   wire             uv_level;
   wire             mr_level;
   wire             mr_filtered;
   wire             strobe_edge;
   wire             driven_level;
   wire             hold_cause;
   wire             wd_active;
   wire             wd_done;
   wire             hold_done;
   wire             bus_req;
   wire             wr_take;
   wire             wd_flag_clr;
   wire             enter_hold;
   wire [31:0]      status_word;
   wire [31:0]      ctrl_word;

   ////////////////////////////////////////////////////////////////////////
   // Input conditioning

   // Supply indication: short dips never reach the state machine
   ssw_pin_filter #(
      .STABLE_CYCLES (UV_FILTER_CYCLES),
      .CNT_W         (DIV_W),
      .INIT_LEVEL    (1'b0)
   ) u_uv_filter (
      .clk     (clk),
      .rst_n   (rst_n),
      .pin     (supply_low_in),
      .level   (uv_level),
      .changed ()
   );

   // Manual reset: glitch rejection and button debounce in one filter
   ssw_pin_filter #(
      .STABLE_CYCLES (MR_CYCLES),
      .CNT_W         (DIV_W),
      .INIT_LEVEL    (1'b1)
   ) u_mr_filter (
      .clk     (clk),
      .rst_n   (rst_n),
      .pin     (manual_reset_in_n),
      .level   (mr_filtered),
      .changed ()
   );

   // Absent manual reset reads as released
   assign mr_level = HAS_MANUAL ? mr_filtered : 1'b1;

   // Strobe: any settled change is an edge
   ssw_pin_filter #(
      .STABLE_CYCLES (STROBE_CYCLES),
      .CNT_W         (DIV_W),
      .INIT_LEVEL    (1'b0)
   ) u_strobe_filter (
      .clk     (clk),
      .rst_n   (rst_n),
      .pin     (watchdog_strobe_in),
      .level   (),
      .changed (strobe_edge)
   );

   // Pad sense of a driven strobe
   ssw_pin_filter #(
      .STABLE_CYCLES (1),
      .CNT_W         (DIV_W),
      .INIT_LEVEL    (1'b0)
   ) u_driven_filter (
      .clk     (clk),
      .rst_n   (rst_n),
      .pin     (watchdog_strobe_driven),
      .level   (driven_level),
      .changed ()
   );

   ////////////////////////////////////////////////////////////////////////
   // Timebase

   assign enter_hold = (next_state == ST_HOLD) && (state != ST_HOLD);

   // Restarting at hold entry keeps the hold at least its minimum
   always @(posedge clk) begin
      if (!rst_n) begin
         div_cnt <= {DIV_W{1'b0}};
         tick    <= 1'b0;
      end else if (enter_hold) begin
         div_cnt <= {DIV_W{1'b0}};
         tick    <= 1'b0;
      end else if (div_cnt >= TICK_LAST) begin
         div_cnt <= {DIV_W{1'b0}};
         tick    <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 1'b1;
         tick    <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset sequencer

   assign hold_cause = uv_level || !mr_level;
   assign hold_done  = tick && (hold_cnt + 1'b1 >= hold_ticks(ctrl_hold_sel));

   always @* begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (hold_cause) begin
               next_state = ST_ASSERT;
            end else if (wd_expired) begin
               next_state = ST_HOLD;
            end
         end
         ST_ASSERT: begin
            if (!hold_cause) begin
               next_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (hold_cause) begin
               next_state = ST_ASSERT;
            end else if (hold_done) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_HOLD;
         end
      endcase
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         state    <= ST_HOLD;
         hold_cnt <= {CNT_W{1'b0}};
      end else begin
         state <= next_state;
         if (next_state != ST_HOLD || enter_hold) begin
            hold_cnt <= {CNT_W{1'b0}};
         end else if (tick) begin
            hold_cnt <= hold_cnt + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdog

   // Disabled when the strobe is not driven or the option is absent
   assign wd_active = (HAS_WATCHDOG != 0) && ctrl_wd_en && driven_level;
   assign wd_done   = tick && (wd_cnt + 1'b1 >= wd_ticks(ctrl_wd_sel));

   always @(posedge clk) begin
      if (!rst_n) begin
         wd_cnt     <= {CNT_W{1'b0}};
         wd_expired <= 1'b0;
      end else begin
         wd_expired <= 1'b0;
         if (state != ST_RUN || hold_cause) begin
            wd_cnt <= {CNT_W{1'b0}};
         end else if (strobe_edge || !wd_active) begin
            wd_cnt <= {CNT_W{1'b0}};
         end else if (wd_done) begin
            wd_cnt     <= {CNT_W{1'b0}};
            wd_expired <= 1'b1;
         end else if (tick) begin
            wd_cnt <= wd_cnt + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset outputs

   always @(posedge clk) begin
      if (!rst_n) begin
         reset_out_n <= 1'b0;
         reset_out   <= 1'b1;
      end else begin
         reset_out_n <= (next_state == ST_RUN);
         reset_out   <= (next_state != ST_RUN);
      end
   end

   // Open drain drives only the low level
   assign reset_out_n_oe = OPEN_DRAIN ? !reset_out_n : 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // Register bus: one wait state per access

   assign bus_req         = avs_read || avs_write;
   assign avs_waitrequest = bus_req && !bus_ack;
   assign wr_take         = avs_write && bus_ack;
   assign wd_flag_clr     = wr_take && (avs_address == `SSW_REG_STATUS) &&
                            avs_byteenable[0] && avs_writedata[`SSW_ST_WDEXP_BIT];

   assign ctrl_word = {27'h0, ctrl_wd_en, ctrl_wd_sel, ctrl_hold_sel};

   assign status_word = {25'h0, state, driven_level, wd_flag,
                         !mr_level, uv_level, !reset_out_n};

   always @(posedge clk) begin
      if (!rst_n) begin
         bus_ack      <= 1'b0;
         avs_readdata <= 32'h00000000;
      end else begin
         bus_ack <= bus_req && !bus_ack;
         if (avs_read && !bus_ack) begin
            case (avs_address)
               `SSW_REG_CTRL:    avs_readdata <= ctrl_word;
               `SSW_REG_STATUS:  avs_readdata <= status_word;
               `SSW_REG_WDCOUNT: avs_readdata <= {14'h0, wd_cnt};
               default:          avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Control register, hold and watchdog selects default from the build options, watchdog enable to 1
   always @(posedge clk) begin
      if (!rst_n) begin
         ctrl_hold_sel <= HOLD_SEL;
         ctrl_wd_sel   <= WD_SEL;
         ctrl_wd_en    <= 1'b1;
      end else if (wr_take && avs_address == `SSW_REG_CTRL && avs_byteenable[0]) begin
         ctrl_hold_sel <= avs_writedata[`SSW_CTRL_HOLD_LSB +: 2];
         ctrl_wd_sel   <= avs_writedata[`SSW_CTRL_WD_LSB +: 2];
         ctrl_wd_en    <= avs_writedata[`SSW_CTRL_WDEN_BIT];
      end
   end

   // Sticky expiry flag; a new expiry beats a clear
   always @(posedge clk) begin
      if (!rst_n) begin
         wd_flag <= 1'b0;
      end else if (wd_expired) begin
         wd_flag <= 1'b1;
      end else if (wd_flag_clr) begin
         wd_flag <= 1'b0;
      end
   end

endmodule

// >>> verification/ssw_top_properties.sv
// Checker for the reset outputs and register bus of the supervisor
module ssw_top_properties #(
   parameter       OPEN_DRAIN       = 0,
   parameter [1:0] HOLD_SEL         = 2'h2,
   parameter       TICK_CYCLES      = 10000,
   parameter       UV_FILTER_CYCLES = 8000
) (
   // Clock and reset
   input logic        clk,
   input logic        rst_n,
   // Supervised inputs
   input logic        supply_low_in,
   input logic        manual_reset_in_n,
   input logic        watchdog_strobe_in,
   input logic        watchdog_strobe_driven,
   // Reset outputs
   input logic        reset_out_n,
   input logic        reset_out_n_oe,
   input logic        reset_out,
   // Avalon-MM slave
   input logic [3:0]  avs_address,
   input logic        avs_read,
   input logic        avs_write,
   input logic [31:0] avs_writedata,
   input logic [3:0]  avs_byteenable,
   input logic [31:0] avs_readdata,
   input logic        avs_waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HOLD_CYC = TICK_CYCLES *
      (HOLD_SEL == 0 ? 10 : HOLD_SEL == 1 ? 200 : HOLD_SEL == 2 ? 1400 : 11200);
   localparam int HOLD_MIN = HOLD_CYC - 2;
   localparam int UV_LATE  = UV_FILTER_CYCLES + 10;
   int mr_lo, mr_hi, uv_lo, uv_hi, out_lo;

   // Run lengths of each cause and of the asserted output
   always @(posedge clk) begin
      if (!rst_n) begin
         mr_lo <= 0;
         mr_hi <= 0;
         uv_lo <= 0;
         uv_hi <= 0;
         out_lo <= 0;
      end else begin
         mr_lo <= manual_reset_in_n ? 0 : mr_lo + 1;
         mr_hi <= manual_reset_in_n ? mr_hi + 1 : 0;
         uv_lo <= supply_low_in ? uv_lo + 1 : 0;
         uv_hi <= supply_low_in ? 0 : uv_hi + 1;
         out_lo <= reset_out_n ? 0 : out_lo + 1;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_dual_level: assert property (reset_out == !reset_out_n)
      else $error("reset outputs not complementary");
   a_drive_enable: assert property (reset_out_n_oe == (OPEN_DRAIN ? !reset_out_n : 1'h1))
      else $error("reset drive enable wrong");
   a_wait_single: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("more than one wait state");
   a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("waitrequest without request");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 4'hC
      |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_uv_asserts: assert property (uv_lo == UV_LATE |-> !reset_out_n)
      else $error("supply low did not assert reset");
   a_mr_asserts: assert property (mr_lo == 2015 |-> !reset_out_n)
      else $error("manual reset did not assert reset");
   a_hold_span: assert property ($rose(reset_out_n) |-> out_lo >= HOLD_MIN)
      else $error("reset shorter than hold period");
   a_mr_hold: assert property ($rose(reset_out_n) |-> mr_hi >= HOLD_MIN)
      else $error("release too soon after manual reset");
   a_uv_hold: assert property ($rose(reset_out_n) |-> uv_hi >= HOLD_MIN)
      else $error("release too soon after supply low");

   cover property ($rose(reset_out_n));
   cover property (mr_lo == 2015);
   cover property (avs_write && !avs_waitrequest);
endmodule

bind ssw_top ssw_top_properties #(.OPEN_DRAIN(OPEN_DRAIN), .HOLD_SEL(HOLD_SEL),
   .TICK_CYCLES(TICK_CYCLES), .UV_FILTER_CYCLES(UV_FILTER_CYCLES)) u_props (
   .clk(clk), .rst_n(rst_n), .supply_low_in(supply_low_in),
   .manual_reset_in_n(manual_reset_in_n), .watchdog_strobe_in(watchdog_strobe_in),
   .watchdog_strobe_driven(watchdog_strobe_driven), .reset_out_n(reset_out_n),
   .reset_out_n_oe(reset_out_n_oe), .reset_out(reset_out), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest));

// >>> verification/ssw_cpu_model.sv
// Processor model that takes the reset and services the watchdog strobe
module ssw_cpu_model (
   // Clock and reset from the supervisor
   input  logic       clk,
   input  logic       reset_in_n,
   // Behaviour controls
   input  logic       run,
   input  logic       float_pin,
   input  logic [9:0] gap,
   // Strobe pin
   output logic       strobe = 1'h0,
   output logic       driven = 1'h1
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] cnt  = 10'h000;
   logic       last = 1'h0;

   always @(posedge clk) begin
      // Stuck code or held reset leaves the strobe static
      // A gap shortened below the count restarts at once instead of wrapping
      if (!reset_in_n || !run || cnt >= gap)
         cnt <= 10'h000;
      else
         cnt <= cnt + 10'h001;
      if (float_pin) begin
         // Released pin drifts away from the last driven level
         driven <= 1'h0;
         strobe <= ~last;
      end else begin
         // Five-cycle high pulse, low for the rest
         driven <= 1'h1;
         strobe <= run && reset_in_n && cnt < 10'h005;
         last <= run && reset_in_n && cnt < 10'h005;
      end
   end
endmodule

// >>> verification/supply_supervisor_watchdog_reset_bench.sv
// Self-checking bench for the supervisor with a processor model
module supply_supervisor_watchdog_reset_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'h0, rst_n = 1'h0, supply_low_in = 1'h0, manual_reset_in_n = 1'h1;
   logic        watchdog_strobe_in, watchdog_strobe_driven;
   logic        reset_out_n, reset_out_n_oe, reset_out, avs_waitrequest;
   logic        od_out_n, od_out_n_oe, od_out;
   logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'h1;
   logic        avs_read = 1'h0, avs_write = 1'h0, run = 1'h0, float_pin = 1'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [9:0]  gap = 10'h0C8;
   logic [31:0] q_bus[$];
   logic [5:0]  q_pin[$];
   int          n_mismatch = 0, check_count = 0, n_fall = 0, n0;

   ssw_top #(.HOLD_SEL(2'h0), .WD_SEL(2'h0), .TICK_CYCLES(10), .UV_FILTER_CYCLES(20)) dut (
      .clk(clk), .rst_n(rst_n), .supply_low_in(supply_low_in),
      .manual_reset_in_n(manual_reset_in_n), .watchdog_strobe_in(watchdog_strobe_in),
      .watchdog_strobe_driven(watchdog_strobe_driven), .reset_out_n(reset_out_n),
      .reset_out_n_oe(reset_out_n_oe), .reset_out(reset_out), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

   // Open-drain build on the same inputs; it may only ever drive the low level
   ssw_top #(.OPEN_DRAIN(1), .HOLD_SEL(2'h0), .WD_SEL(2'h0), .TICK_CYCLES(10),
      .UV_FILTER_CYCLES(20)) dut_od (
      .clk(clk), .rst_n(rst_n), .supply_low_in(supply_low_in),
      .manual_reset_in_n(manual_reset_in_n), .watchdog_strobe_in(watchdog_strobe_in),
      .watchdog_strobe_driven(watchdog_strobe_driven), .reset_out_n(od_out_n),
      .reset_out_n_oe(od_out_n_oe), .reset_out(od_out), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(), .avs_waitrequest());

   ssw_cpu_model cpu (.clk(clk), .reset_in_n(reset_out_n), .run(run), .float_pin(float_pin),
      .gap(gap), .strobe(watchdog_strobe_in), .driven(watchdog_strobe_driven));

   initial begin
      forever #5 clk = ~clk;
   end

   always @(negedge reset_out_n) n_fall++;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task test_done;
      $display("mismatches %0d, checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // One Avalon transfer, held until a rising edge samples waitrequest low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n = 0;
      if (!w) q_bus.push_back(d);
      @(posedge clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= w ? d : 32'h0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 50);
      if (n >= 50) chk(n, 0);
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask

   // Counts cycles until the reset output reaches lvl, inside lo..hi
   task automatic wait_pin(input logic lvl, input int lo, input int hi);
      int n = 0;
      while (reset_out_n !== lvl && n < hi + 5) begin
         @(negedge clk);
         n++;
      end
      chk((n >= lo && n <= hi) ? lo : n, lo);
      // Push-pull drives both levels; open drain only drives low
      q_pin.push_back(lvl ? 6'h2C : 6'h1B);
   endtask

   task idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Result watcher: compares each settled result with the oldest note
   always @(posedge clk) begin
      if (avs_read && avs_waitrequest === 1'h0 && q_bus.size() > 0)
         chk(avs_readdata, q_bus.pop_front());
      if (q_pin.size() > 0)
         chk({reset_out_n, reset_out, reset_out_n_oe, od_out_n, od_out, od_out_n_oe},
             q_pin.pop_front());
   end

   initial begin
      #500000;
      n_mismatch++;
      test_done();
   end

   initial begin
      void'($urandom(32189));
      idle(2);
      rst_n <= 1'h1;
      run <= 1'h1;
      wait_pin(1'h1, 95, 125);
      bus(1'h0, 4'h0, 32'h10);
      bus(1'h0, 4'hC, 32'h0);
      bus(1'h1, 4'hC, 32'hFF);
      bus(1'h0, 4'h4, 32'h10);
      ///////////////////////////////////////////////////////////////////
      n0 = n_fall;
      repeat (6) begin
         gap <= 10'($urandom_range(20, 500));
         idle(500);
      end
      chk(n_fall, n0);
      @(negedge watchdog_strobe_in);
      @(posedge clk);
      run <= 1'h0;
      wait_pin(1'h0, 625, 660);
      run <= 1'h1;
      wait_pin(1'h1, 95, 125);
      bus(1'h0, 4'h4, 32'h18);
      bus(1'h1, 4'h4, 32'h8);
      bus(1'h0, 4'h4, 32'h10);
      ///////////////////////////////////////////////////////////////////
      n0 = n_fall;
      float_pin <= 1'h1;
      idle(1500);
      chk(n_fall, n0);
      bus(1'h0, 4'h4, 32'h0);
      float_pin <= 1'h0;
      idle(20);
      ///////////////////////////////////////////////////////////////////
      n0 = n_fall;
      repeat (5) begin
         manual_reset_in_n <= 1'h0;
         idle($urandom_range(1, 1500));
         manual_reset_in_n <= 1'h1;
         idle($urandom_range(5, 50));
      end
      chk(n_fall, n0);
      manual_reset_in_n <= 1'h0;
      wait_pin(1'h0, 1995, 2030);
      bus(1'h0, 4'h8, 32'h0);
      manual_reset_in_n <= 1'h1;
      wait_pin(1'h1, 2090, 2140);
      chk(n_fall, n0 + 1);
      ///////////////////////////////////////////////////////////////////
      n0 = n_fall;
      supply_low_in <= 1'h1;
      idle(15);
      supply_low_in <= 1'h0;
      idle(50);
      chk(n_fall, n0);
      supply_low_in <= 1'h1;
      wait_pin(1'h0, 18, 40);
      idle(300);
      bus(1'h0, 4'h8, 32'h0);
      supply_low_in <= 1'h0;
      wait_pin(1'h1, 98, 140);
      idle(5);
      test_done();
   end
endmodule
